// file: logic/dml_pkg.sv
// Shared constants and carrier types for the dot-matrix serial loader.
// Assumes a single 10 MHz system clock and a 32-bit APB register port.

`default_nettype none

package dml_pkg;

  // ----------------------------------------------------------------------
  // Clock and display oscillator timing
  // ----------------------------------------------------------------------
  localparam int CLK_KHZ = 10000;
  localparam int INT_OSC_MIN_KHZ = 80;
  localparam int INT_OSC_MAX_KHZ = 210;
  localparam int INT_OSC_TARGET_KHZ = 150;
  localparam int INT_OSC_HALF = CLK_KHZ / (2 * INT_OSC_TARGET_KHZ);
  localparam int REFRESH_DIV = 512;
  localparam int PRESCALE_DIV = 8;

  // ----------------------------------------------------------------------
  // Control shift register layout
  // ----------------------------------------------------------------------
  localparam int CTRL_BITS = 8;
  localparam int CW_BITS = 7;
  localparam int CW_SEL_BIT = 7;
  localparam int CW0_PWM_LSB = 0;
  localparam int CW0_PEAK_LSB = 4;
  localparam int CW0_AWAKE_BIT = 6;
  localparam int CW1_SIMUL_BIT = 0;
  localparam int CW1_PRESCALE_BIT = 1;

  // ----------------------------------------------------------------------
  // APB register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_DOT_IDX = 8'h08;
  localparam logic [7:0] REG_DOT_WORD = 8'h0C;
  localparam int CTRL_FORCE_BLANK_BIT = 0;
  localparam int ST_CW0_LSB = 0;
  localparam int ST_CW1_LSB = 8;
  localparam int ST_RS_BIT = 16;
  localparam int ST_PEND_BIT = 17;
  localparam int ST_SLEEP_BIT = 18;
  localparam int ST_CE_BIT = 19;
  localparam int DOT_IDX_BITS = 3;

  // ----------------------------------------------------------------------
  // Carriers for pin groups crossing into the system clock
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic din;
    logic sclk;
    logic ce_b;
    logic rs;
  } dml_link_t;

  typedef struct packed {
    logic blank;
    logic osc_sel;
    logic osc_ext;
  } dml_aux_t;

  localparam dml_link_t LINK_IDLE = '{din: 1'h0, sclk: 1'h0,
                                      ce_b: 1'h1, rs: 1'h0};
  localparam dml_aux_t AUX_IDLE = '{blank: 1'h1, osc_sel: 1'h1,
                                    osc_ext: 1'h0};

endpackage

`default_nettype wire

// file: logic/dml_loader.sv
// Serial write port, control words and refresh logic of a dot-matrix
// LED driver. The serial pins and the oscillator pin are asynchronous to
// clk_in and are sampled through two flip-flops; the shift clock must stay
// well below half the system clock rate.
//
// Function
// - Reset low clears every control register bit; high is normal operation.
// - Reset leaves the dot pattern register untouched.
// - With enable low, each shift clock rising edge captures the data bit.
// - Select low targets dot register, select high the control register.
// - Select level is held at enable falling edge for the whole write.
// - Enable high with shift clock low copies shifted data to its target.
// - Serial output carries shift data onward for chained displays.
// - Oscillator select low picks external, high picks internal source.
// - Oscillator pin drives internal clock, or accepts external clock.
// - Blank high turns all LEDs off; may be modulated for brightness.
// - Sleep stops the internal oscillator and LED reference current.
// - Internal display oscillator runs between 80 and 210 kHz.
// - Dot pattern register holds 160 bits, one bit per LED.
// - Control write is eight bits, most significant first, then enable high.
// - Top control bit picks the word updated; the other keeps its value.
// - Reset also enters sleep, so LEDs stay dark until configured.

`timescale 1ns/1ps
`default_nettype none

module dml_loader
  import dml_pkg::*;
#(
  parameter int DOT_BITS = 160
) (
  // System
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Serial write pins
  input wire logic ser_data_in,
  input wire logic shift_clk_in,
  input wire logic chip_en_b_in,
  input wire logic register_select_in,
  output logic ser_data_out,
  // Display oscillator and blanking
  input wire logic osc_sel_in,
  input wire logic display_osc_pin_in,
  output logic display_osc_pin_out,
  output logic display_osc_pin_oe_out,
  input wire logic blank_in,
  // LED drive
  output logic [DOT_BITS-1:0] led_out,
  output logic [1:0] peak_current_out,
  output logic ref_current_en_out,
  output logic refresh_tick_out,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out
);

  localparam int DOT_WORDS = DOT_BITS / 32;

  if (DOT_BITS % 32 != 0 || DOT_WORDS < 1 || DOT_WORDS > 8) begin : g_chk
    $error("DOT_BITS must be a multiple of 32 up to 256");
  end
  if (CLK_KHZ / (2 * INT_OSC_HALF) < INT_OSC_MIN_KHZ ||
      CLK_KHZ / (2 * INT_OSC_HALF) > INT_OSC_MAX_KHZ) begin : g_osc
    $error("Internal oscillator divider out of range");
  end

  function automatic logic [31:0] dot_word(input logic [DOT_BITS-1:0] v,
                                           input logic [2:0] idx);
    dot_word = 32'h0;
    for (int i = 0; i < DOT_WORDS; i++) begin
      if (idx == 3'(i)) begin
        dot_word = v[i*32 +: 32];
      end
    end
  endfunction

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  dml_link_t link_meta_ff, link_s_ff;
  dml_aux_t aux_meta_ff, aux_s_ff;
  logic sclk_prev_ff, ce_prev_ff, ext_prev_ff;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      link_meta_ff <= LINK_IDLE;
      link_s_ff <= LINK_IDLE;
      aux_meta_ff <= AUX_IDLE;
      aux_s_ff <= AUX_IDLE;
      sclk_prev_ff <= 1'h0;
      ce_prev_ff <= 1'h1;
      ext_prev_ff <= 1'h0;
    end else begin
      link_meta_ff <= '{din: ser_data_in, sclk: shift_clk_in,
                        ce_b: chip_en_b_in, rs: register_select_in};
      link_s_ff <= link_meta_ff;
      aux_meta_ff <= '{blank: blank_in, osc_sel: osc_sel_in,
                       osc_ext: display_osc_pin_in};
      aux_s_ff <= aux_meta_ff;
      sclk_prev_ff <= link_s_ff.sclk;
      ce_prev_ff <= link_s_ff.ce_b;
      ext_prev_ff <= aux_s_ff.osc_ext;
    end
  end

  logic clk_rise, ce_fall, shift_en;
  assign clk_rise = link_s_ff.sclk & ~sclk_prev_ff;
  assign ce_fall = ~link_s_ff.ce_b & ce_prev_ff;
  // Edges seen while enable is high are ignored.
  assign shift_en = clk_rise & ~link_s_ff.ce_b;

  // ----------------------------------------------------------------------
  // Write sequencing
  // ----------------------------------------------------------------------
  logic rs_sel_ff, pend_ff, latch_go;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rs_sel_ff <= 1'h0;
    end else if (ce_fall) begin
      rs_sel_ff <= link_s_ff.rs;
    end
  end

  // A transfer needs enable high, so it never meets a shift in one cycle.
  assign latch_go = pend_ff & link_s_ff.ce_b & ~link_s_ff.sclk;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pend_ff <= 1'h0;
    end else if (shift_en) begin
      pend_ff <= 1'h1;
    end else if (latch_go) begin
      pend_ff <= 1'h0;
    end
  end

  // ----------------------------------------------------------------------
  // Dot pattern path; no reset so contents survive a chip reset
  // ----------------------------------------------------------------------
  logic [DOT_BITS-1:0] dot_shift_ff, dot_latch_ff;

  always_ff @(posedge clk_in) begin
    if (shift_en && !rs_sel_ff) begin
      dot_shift_ff <= {dot_shift_ff[DOT_BITS-2:0], link_s_ff.din};
    end
  end

  always_ff @(posedge clk_in) begin
    if (latch_go && !rs_sel_ff) begin
      dot_latch_ff <= dot_shift_ff;
    end
  end

  // ----------------------------------------------------------------------
  // Control shift register and control words
  // ----------------------------------------------------------------------
  logic [CTRL_BITS-1:0] ctrl_shift_ff;
  logic [CW_BITS-1:0] cw0_ff, cw1_ff;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl_shift_ff <= '0;
    end else if (shift_en && rs_sel_ff) begin
      ctrl_shift_ff <= {ctrl_shift_ff[CTRL_BITS-2:0], link_s_ff.din};
    end
  end

  // The word is picked by the bit that was shifted in first.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cw0_ff <= '0;
      cw1_ff <= '0;
    end else if (latch_go && rs_sel_ff) begin
      if (ctrl_shift_ff[CW_SEL_BIT]) begin
        cw1_ff <= ctrl_shift_ff[CW_BITS-1:0];
      end else begin
        cw0_ff <= ctrl_shift_ff[CW_BITS-1:0];
      end
    end
  end

  logic awake;
  assign awake = cw0_ff[CW0_AWAKE_BIT];

  // ----------------------------------------------------------------------
  // Cascade output
  // ----------------------------------------------------------------------
  logic dout_ff;

  // Simultaneous mode passes data straight through, three flops late.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      dout_ff <= 1'h0;
    end else if (cw1_ff[CW1_SIMUL_BIT]) begin
      dout_ff <= link_s_ff.din;
    end else if (rs_sel_ff) begin
      dout_ff <= ctrl_shift_ff[CTRL_BITS-1];
    end else begin
      dout_ff <= dot_shift_ff[DOT_BITS-1];
    end
  end
  assign ser_data_out = dout_ff;

  // ----------------------------------------------------------------------
  // Display oscillator
  // ----------------------------------------------------------------------
  logic [7:0] int_cnt_ff;
  logic int_osc_ff, int_tick;
  logic [2:0] pre_cnt_ff;
  logic ext_rise, ext_tick, osc_tick;

  // Sleep freezes the internal divider.
  assign int_tick = aux_s_ff.osc_sel & awake &
                    (int_cnt_ff == 8'(INT_OSC_HALF - 1)) & ~int_osc_ff;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      int_cnt_ff <= '0;
      int_osc_ff <= 1'h0;
    end else if (aux_s_ff.osc_sel && awake) begin
      if (int_cnt_ff == 8'(INT_OSC_HALF - 1)) begin
        int_cnt_ff <= '0;
        int_osc_ff <= ~int_osc_ff;
      end else begin
        int_cnt_ff <= int_cnt_ff + 8'h01;
      end
    end
  end

  assign ext_rise = aux_s_ff.osc_ext & ~ext_prev_ff;
  assign ext_tick = ext_rise & (~cw1_ff[CW1_PRESCALE_BIT] |
                                (pre_cnt_ff == 3'(PRESCALE_DIV - 1)));

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pre_cnt_ff <= '0;
    end else if (ext_rise && cw1_ff[CW1_PRESCALE_BIT]) begin
      pre_cnt_ff <= pre_cnt_ff + 3'h1;
    end
  end

  assign osc_tick = aux_s_ff.osc_sel ? int_tick : ext_tick;
  assign display_osc_pin_out = int_osc_ff;
  assign display_osc_pin_oe_out = aux_s_ff.osc_sel;

  // ----------------------------------------------------------------------
  // Refresh phase, brightness and LED drive
  // ----------------------------------------------------------------------
  logic [8:0] phase_ff;
  logic refresh_ff, pwm_on, force_blank_ff;
  logic [DOT_BITS-1:0] led_ff;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      phase_ff <= '0;
      refresh_ff <= 1'h0;
    end else begin
      refresh_ff <= osc_tick && awake &&
                    (phase_ff == 9'(REFRESH_DIV - 1));
      if (osc_tick && awake) begin
        phase_ff <= phase_ff + 9'h001;
      end
    end
  end

  assign pwm_on = phase_ff[8:5] <= cw0_ff[CW0_PWM_LSB +: 4];

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      led_ff <= '0;
    end else if (!awake || aux_s_ff.blank || force_blank_ff || !pwm_on) begin
      led_ff <= '0;
    end else begin
      led_ff <= dot_latch_ff;
    end
  end

  assign led_out = led_ff;
  assign peak_current_out = cw0_ff[CW0_PEAK_LSB +: 2];
  assign ref_current_en_out = awake;
  assign refresh_tick_out = refresh_ff;

  // ----------------------------------------------------------------------
  // APB slave, zero wait states
  // ----------------------------------------------------------------------
  logic [DOT_IDX_BITS-1:0] dot_idx_ff;
  logic [31:0] rdata_ff;
  logic mapped, wr_acc;
  logic [31:0] status_word;

  assign mapped = (paddr_in == REG_CTRL) || (paddr_in == REG_STATUS) ||
                  (paddr_in == REG_DOT_IDX) || (paddr_in == REG_DOT_WORD);
  assign wr_acc = psel_in & penable_in & pwrite_in & mapped;
  assign pready_out = 1'h1;
  assign pslverr_out = psel_in & penable_in & ~mapped;

  always_comb begin
    status_word = 32'h0;
    status_word[ST_CW0_LSB +: CW_BITS] = cw0_ff;
    status_word[ST_CW1_LSB +: CW_BITS] = cw1_ff;
    status_word[ST_RS_BIT] = rs_sel_ff;
    status_word[ST_PEND_BIT] = pend_ff;
    status_word[ST_SLEEP_BIT] = ~awake;
    status_word[ST_CE_BIT] = link_s_ff.ce_b;
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      force_blank_ff <= 1'h0;
      dot_idx_ff <= '0;
    end else if (wr_acc && paddr_in == REG_CTRL) begin
      force_blank_ff <= pwdata_in[CTRL_FORCE_BLANK_BIT];
    end else if (wr_acc && paddr_in == REG_DOT_IDX) begin
      dot_idx_ff <= pwdata_in[DOT_IDX_BITS-1:0];
    end
  end

  // Read data is captured in the setup cycle and held for the access.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_ff <= 32'h0;
    end else if (psel_in && !penable_in) begin
      unique case (paddr_in)
        REG_CTRL: rdata_ff <= {31'h0, force_blank_ff};
        REG_STATUS: rdata_ff <= status_word;
        REG_DOT_IDX: rdata_ff <= {29'h0, dot_idx_ff};
        REG_DOT_WORD: rdata_ff <= dot_word(dot_latch_ff, dot_idx_ff);
        default: rdata_ff <= 32'h0;
      endcase
    end
  end
  assign prdata_out = rdata_ff;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  reset_clear_a: assert property ($rose(rst_b_in) |->
    cw0_ff == '0 && cw1_ff == '0) else $error("control not cleared");
  reset_sleep_a: assert property ($rose(rst_b_in) |->
    !ref_current_en_out && led_out == '0) else $error("not asleep");
  shift_capture_a: assert property (shift_en && !rs_sel_ff |=>
    dot_shift_ff[0] == $past(link_s_ff.din)) else $error("bit lost");
  select_hold_a: assert property (ce_fall ##1 !ce_fall [*3] |->
    rs_sel_ff == $past(link_s_ff.rs, 3)) else $error("select drift");
  ce_high_ignore_a: assert property (link_s_ff.ce_b |=>
    $stable(ctrl_shift_ff)) else $error("shift with enable high");
  latch_copy_a: assert property (latch_go && !rs_sel_ff |=>
    dot_latch_ff == $past(dot_shift_ff)) else $error("dot copy wrong");
  word_keep_a: assert property (latch_go && rs_sel_ff &&
    !ctrl_shift_ff[CW_SEL_BIT] |=> $stable(cw1_ff) &&
    cw0_ff == $past(ctrl_shift_ff[CW_BITS-1:0])) else $error("word mixup");
  blank_dark_a: assert property (aux_s_ff.blank |=>
    led_out == '0) else $error("lit while blanked");
  sleep_osc_a: assert property (!awake |->
    !ref_current_en_out ##1 $stable(int_osc_ff))
    else $error("osc in sleep");
  pattern_hold_a: assert property (!latch_go |=>
    $stable(dot_latch_ff)) else $error("pattern changed early");
  // The select pin reaches the enable two flops late; reset idles it high.
  osc_dir_a: assert property ($past(rst_b_in, 2) |->
    display_osc_pin_oe_out == $past(osc_sel_in, 2))
    else $error("osc pin direction");

  dot_load_c: cover property (latch_go && !rs_sel_ff);
  word1_load_c: cover property (latch_go && rs_sel_ff &&
                                ctrl_shift_ff[CW_SEL_BIT]);
  refresh_c: cover property (refresh_ff);
  blank_c: cover property (awake && aux_s_ff.blank);

endmodule

`default_nettype wire

// file: testbench/dml_host_model.sv
// Controller model that writes the serial pins of the dot-matrix loader.
// Assumes a 10 MHz clk_in; every pin changes just after its rising edge.

`timescale 1ns/1ps
`default_nettype none

module dml_host_model (
  // System
  input wire logic clk_in,
  // Serial pins
  output logic ser_data_out,
  output logic shift_clk_out,
  output logic chip_en_b_out,
  output logic register_select_out
);

  initial begin
    ser_data_out = 1'h0;
    shift_clk_out = 1'h0;
    chip_en_b_out = 1'h1;
    register_select_out = 1'h0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // Four system clocks a phase give the 800 ns shift clock.
  task automatic pulse(input logic bit_val);
    ser_data_out <= bit_val;
    wait_clk(4);
    shift_clk_out <= 1'h1;
    wait_clk(4);
    shift_clk_out <= 1'h0;
  endtask

  // Flip moves select after enable falls; close ends the write.
  task automatic send(input logic rs, input int n, input logic [159:0] bits,
                      input logic flip, input logic close);
    wait_clk(1);
    register_select_out <= rs;
    wait_clk(4);
    chip_en_b_out <= 1'h0;
    wait_clk(4);
    if (flip) begin
      register_select_out <= ~rs;
    end
    for (int i = n - 1; i >= 0; i--) begin
      pulse(bits[i]);
    end
    wait_clk(4);
    if (close) begin
      end_write();
    end
  endtask

  // A released data line shows the inverse so stale bits never match.
  task automatic end_write();
    wait_clk(1);
    chip_en_b_out <= 1'h1;
    ser_data_out <= ~ser_data_out;
    wait_clk(8);
  endtask

  task automatic stray(input int n);
    wait_clk(1);
    for (int i = 0; i < n; i++) begin
      pulse(1'h1);
    end
  endtask

endmodule

`default_nettype wire

// file: testbench/dml_loader_test.sv
// Self-checking bench for the dot-matrix loader.
// Assumes the serial host model and an APB master built from tasks.

`timescale 1ns/1ps
`default_nettype none

module dml_loader_test;
  import dml_pkg::*;

  localparam logic [159:0] PAT = {32'hA5C30F1E, 32'h12345678,
                                  32'h80000001, 32'hFFFF0000, 32'h0F0FF0F0};
  logic clk_in = 1'h0;
  logic rst_b_in = 1'h0;
  logic osc_sel_in = 1'h1;
  logic blank_in = 1'h0;
  logic ext_osc = 1'h0;
  logic ext_on = 1'h0;
  logic psel_in = 1'h0;
  logic penable_in = 1'h0;
  logic pwrite_in = 1'h0;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0;
  logic [31:0] rd_data;
  logic rd_err;
  wire logic ser_d, sclk, ce_b, rs, dout, osc_out, osc_oe, osc_wire;
  wire logic ref_en, tick, pready, pslverr;
  wire logic [159:0] led;
  wire logic [1:0] peak;
  wire logic [31:0] prdata;
  int failures = 0;
  int num_checks = 0;
  int osc_cnt = 0;
  int p;
  int g;

  always #50 clk_in = ~clk_in;

  // The shared pin level follows whoever holds its enable.
  assign osc_wire = osc_oe ? osc_out : ext_osc;

  // External source at 500 kHz, inside the divide-by-one range.
  always @(posedge clk_in) begin
    if (ext_on) begin
      osc_cnt <= (osc_cnt == 9) ? 0 : osc_cnt + 1;
      ext_osc <= (osc_cnt == 9) ? ~ext_osc : ext_osc;
    end
  end

  dml_host_model u_dml_host_model (.clk_in(clk_in), .ser_data_out(ser_d),
    .shift_clk_out(sclk), .chip_en_b_out(ce_b), .register_select_out(rs));

  dml_loader u_dml_loader (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .ser_data_in(ser_d), .shift_clk_in(sclk), .chip_en_b_in(ce_b),
    .register_select_in(rs), .ser_data_out(dout), .osc_sel_in(osc_sel_in),
    .display_osc_pin_in(osc_wire), .display_osc_pin_out(osc_out),
    .display_osc_pin_oe_out(osc_oe), .blank_in(blank_in), .led_out(led),
    .peak_current_out(peak), .ref_current_en_out(ref_en),
    .refresh_tick_out(tick), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr));

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  // Waits as long as the slave needs; only the watchdog ends a hang.
  task automatic apb(input logic wr, input logic [7:0] addr,
                     input logic [31:0] wdata);
    @(posedge clk_in);
    psel_in <= 1'h1;
    pwrite_in <= wr;
    paddr_in <= addr;
    pwdata_in <= wdata;
    @(posedge clk_in);
    penable_in <= 1'h1;
    do begin
      @(posedge clk_in);
    end while (pready !== 1'h1);
    rd_data = prdata;
    rd_err = pslverr;
    psel_in <= 1'h0;
    penable_in <= 1'h0;
  endtask

  task automatic chk_led(input logic [159:0] exp);
    for (int i = 0; i < 5; i++) begin
      chk("led_out", exp[i*32+:32], led[i*32+:32]);
    end
  endtask

  task automatic chk_dots(input logic [159:0] exp);
    for (int i = 0; i < 5; i++) begin
      apb(1'h1, REG_DOT_IDX, i);
      apb(1'h0, REG_DOT_WORD, 32'h0);
      chk("dot word", exp[i*32+:32], rd_data);
    end
  endtask

  task automatic tick_gap(output int gap);
    int n;
    n = 0;
    while (tick !== 1'h1 && n < 40000) begin
      @(negedge clk_in);
      n++;
    end
    @(negedge clk_in);
    gap = 1;
    while (tick !== 1'h1 && gap < 40000) begin
      @(negedge clk_in);
      gap++;
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #12000000;
    failures++;
    wrap_up();
  end

  initial begin
    repeat (10) @(posedge clk_in);
    rst_b_in <= 1'h1;
    cycles(4);
    chk("ref_current_en", 0, ref_en);
    chk("osc oe", 1, osc_oe);
    apb(1'h0, REG_STATUS, 32'h0);
    chk("status", 32'h000C0000, rd_data & 32'h000C7F7F);
    g = 0;
    repeat (300) begin
      @(negedge clk_in);
      g += (osc_out !== 1'h0) + (tick !== 1'h0);
    end
    chk("sleep activity", 0, g);
    $display("reset test done");
    u_dml_host_model.send(1'h1, 8, 160'h5F, 1'h0, 1'h1);
    cycles(8);
    apb(1'h0, REG_STATUS, 32'h0);
    chk("cw0", 32'h5F, rd_data & 32'h7F);
    chk("peak", 1, peak);
    chk("ref_current_en", 1, ref_en);
    chk("ser_data_out", 0, dout);
    u_dml_host_model.send(1'h1, 8, 160'h80, 1'h0, 1'h1);
    cycles(8);
    apb(1'h0, REG_STATUS, 32'h0);
    chk("cw1 and cw0", 32'h005F, rd_data & 32'h7F7F);
    chk("ser_data_out", 1, dout);
    u_dml_host_model.send(1'h1, 8, 160'hC0, 1'h1, 1'h1);
    cycles(8);
    apb(1'h0, REG_STATUS, 32'h0);
    chk("held select", 32'h405F, rd_data & 32'h7F7F);
    u_dml_host_model.stray(4);
    cycles(8);
    apb(1'h0, REG_STATUS, 32'h0);
    chk("stray clocks", 32'h405F, rd_data & 32'h00027F7F);
    // Simultaneous mode: the released data line (low) must pass straight
    // through, where serial mode would show the shift register's top bit.
    u_dml_host_model.send(1'h1, 8, 160'h81, 1'h0, 1'h1);
    cycles(8);
    chk("simultaneous low", 0, dout);
    u_dml_host_model.stray(1);
    cycles(4);
    chk("simultaneous high", 1, dout);
    u_dml_host_model.send(1'h1, 8, 160'hC0, 1'h0, 1'h1);
    cycles(8);
    apb(1'h0, REG_STATUS, 32'h0);
    chk("serial again", 32'h405F, rd_data & 32'h7F7F);
    $display("control test done");
    u_dml_host_model.send(1'h0, 160, PAT, 1'h0, 1'h1);
    cycles(8);
    chk_led(PAT);
    chk_dots(PAT);
    chk("ser_data_out", PAT[159], dout);
    u_dml_host_model.send(1'h0, 160, ~PAT, 1'h0, 1'h0);
    cycles(8);
    chk_led(PAT);
    u_dml_host_model.end_write();
    cycles(8);
    chk_led(~PAT);
    $display("dot test done");
    @(posedge clk_in);
    blank_in <= 1'h1;
    cycles(8);
    chk_led(160'h0);
    @(posedge clk_in);
    blank_in <= 1'h0;
    apb(1'h1, REG_CTRL, 32'h1);
    cycles(4);
    chk_led(160'h0);
    apb(1'h0, REG_CTRL, 32'h0);
    chk("ctrl", 32'h1, rd_data);
    chk("slave error", 0, rd_err);
    apb(1'h1, REG_CTRL, 32'h0);
    cycles(4);
    chk_led(~PAT);
    apb(1'h0, 8'h10, 32'h0);
    chk("pslverr", 1, rd_err);
    chk("unmapped", 32'h0, rd_data);
    $display("blank test done");
    p = 0;
    while (osc_out !== 1'h0 && p < 300) begin @(negedge clk_in); p++; end
    while (osc_out !== 1'h1 && p < 300) begin @(negedge clk_in); p++; end
    p = 0;
    while (osc_out !== 1'h0 && p < 300) begin @(negedge clk_in); p++; end
    while (osc_out !== 1'h1 && p < 300) begin @(negedge clk_in); p++; end
    chk("osc period", 1, p >= 48 && p <= 125);
    tick_gap(g);
    chk("refresh internal", 512 * p, g);
    @(posedge clk_in);
    osc_sel_in <= 1'h0;
    ext_on <= 1'h1;
    cycles(6);
    chk("osc oe", 0, osc_oe);
    tick_gap(g);
    chk("refresh external", 10240, g);
    $display("oscillator test done");
    @(posedge clk_in);
    rst_b_in <= 1'h0;
    cycles(2);
    @(posedge clk_in);
    rst_b_in <= 1'h1;
    cycles(4);
    apb(1'h0, REG_STATUS, 32'h0);
    chk("status", 32'h00040000, rd_data & 32'h00047F7F);
    chk("ref_current_en", 0, ref_en);
    chk_dots(~PAT);
    $display("second reset test done");
    wrap_up();
  end

endmodule

`default_nettype wire
